// [src/vipu_top.sv]
/*
 * Vectored interrupt priority unit: fixed-priority trap and interrupt
 * vectors, first pending-request bank, APB register slave.
 * Assumes pins and event pulses synchronous to pclk; the core takes a
 * vector by pulsing vec_ack while vec_valid is high.
 */
// What this block does
// - Reset ranks highest, vector 0002H, treated as non-interrupt event.
// - Watchdog time-out ranks below reset, vector 0004H.
// - Primary oscillator failure is a trap below watchdog, vector 003AH.
// - Watchdog oscillator failure trap ranks next, vector 003CH.
// - Illegal instruction trap ranks below oscillator traps, vector 0006H.
// - Port A pin 7 selectable edge, vector 0018H, highest port source.
// - Pin 6 edge or comparator event requests vector 001AH.
// - Pins 5 and 4 selectable edges, vectors 001CH and 001EH.
// - Port A or D pin 3 selectable edge share vector 0020H.
// - Port A or D pin 2 selectable edge share vector 0022H.
// - Pins 1 and 0 selectable edges, vectors 0024H and 0026H.
// - Port C pins 3..1 request on both edges, 0030H, 0032H, 0034H.
// - A presented request sets its pending bit.
// - With global enable, pending requests go to the core.
// - With global enable off, only reset and traps go out; software polls.
// - Bank one: eight read/write bits at index FC3H, reset zero.
// - A one means a request awaits service; zero means none.
`include "vipu_defs.svh"
`timescale 1ns/1ns
`default_nettype none

module vipu_top #(
	parameter int NSRC = `VIPU_NSRC
) (
	input  wire logic                 pclk,
	input  wire logic                 presetn,
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [15:0]          paddr,
	input  wire logic [31:0]          pwdata,
	output logic      [31:0]          prdata,
	output logic                      pready,
	output logic                      pslverr,
	input  wire vipu_pkg::vipu_pins_t   pins,
	input  wire vipu_pkg::vipu_events_t events,
	output logic                      vec_valid,
	output logic      [15:0]          vec_addr,
	input  wire logic                 vec_ack,
	output logic                      irq
);

	// ----------------------------------------
	// Vector lookup and priority encoder
	// ----------------------------------------
	function automatic logic [15:0] vec_of(input logic [4:0] i);
		case (i)
			5'h00: vec_of = `VIPU_VEC_RESET;
			5'h01: vec_of = `VIPU_VEC_WDT;
			5'h02: vec_of = `VIPU_VEC_POSC;
			5'h03: vec_of = `VIPU_VEC_WOSC;
			5'h04: vec_of = `VIPU_VEC_ILL;
			5'h05: vec_of = `VIPU_VEC_T1;
			5'h06: vec_of = `VIPU_VEC_T0;
			5'h07: vec_of = `VIPU_VEC_RX;
			5'h08: vec_of = `VIPU_VEC_TX;
			5'h09: vec_of = `VIPU_VEC_ADC;
			5'h0A: vec_of = `VIPU_VEC_PA7;
			5'h0B: vec_of = `VIPU_VEC_PA6;
			5'h0C: vec_of = `VIPU_VEC_PA5;
			5'h0D: vec_of = `VIPU_VEC_PA4;
			5'h0E: vec_of = `VIPU_VEC_PA3;
			5'h0F: vec_of = `VIPU_VEC_PA2;
			5'h10: vec_of = `VIPU_VEC_PA1;
			5'h11: vec_of = `VIPU_VEC_PA0;
			5'h12: vec_of = `VIPU_VEC_PC3;
			5'h13: vec_of = `VIPU_VEC_PC2;
			5'h14: vec_of = `VIPU_VEC_PC1;
			default: vec_of = 16'h0000;
		endcase
	endfunction

	// Lowest index wins, index order is priority order
	function automatic logic [4:0] first_of(input logic [NSRC-1:0] v);
		first_of = 5'h1F;
		for (int i = NSRC - 1; i >= 0; i--) begin
			if (v[i]) begin
				first_of = 5'(i);
			end
		end
	endfunction

	// Bank one keeps pin 7 in bit 7, yet pin 7 outranks pin 0: mirror it
	function automatic logic [7:0] rev8(input logic [7:0] v);
		for (int i = 0; i < 8; i++) begin
			rev8[i] = v[7 - i];
		end
	endfunction

	// ----------------------------------------
	// State
	// ----------------------------------------
	logic        gie_reg;
	logic [7:0]  edge_reg;
	logic [7:0]  bank1_reg;
	logic [7:0]  bank1_next;
	logic [9:0]  other_reg;
	logic [9:0]  other_next;
	logic [3:0]  status_reg;
	logic [3:0]  status_next;
	logic [3:0]  enable_reg;
	logic [12:0] prev_reg;
	logic        primed_reg;
	logic [31:0] rdata_reg;
	logic        vvalid_reg;
	logic [4:0]  vidx_reg;
	logic [15:0] vaddr_reg;

	// ----------------------------------------
	// APB decode
	// ----------------------------------------
	wire         setup   = psel & ~penable;
	wire         wr      = psel & penable & pwrite;
	wire  [11:0] idx     = paddr[13:2];
	wire         aligned = (paddr[1:0] == 2'b00) & (paddr[15:14] == 2'b00);
	wire         hit_ctl = aligned & (idx == `VIPU_IDX_CTRL);
	wire         hit_edg = aligned & (idx == `VIPU_IDX_EDGE);
	wire         hit_bk1 = aligned & (idx == `VIPU_IDX_BANK1);
	wire         hit_sts = aligned & (idx == `VIPU_IDX_STATUS);
	wire         hit_clr = aligned & (idx == `VIPU_IDX_CLEAR);
	wire         hit_ena = aligned & (idx == `VIPU_IDX_ENABLE);
	wire         mapped  = hit_ctl | hit_edg | hit_bk1 | hit_sts | hit_clr | hit_ena;

	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~mapped;
	assign prdata  = rdata_reg;

	// Read mux; clear register reads as zero
	wire [31:0] rmux =
		hit_ctl ? {31'h0, gie_reg} :
		hit_edg ? {24'h0, edge_reg} :
		hit_bk1 ? {24'h0, bank1_reg} :
		hit_sts ? {28'h0, status_reg} :
		hit_ena ? {28'h0, enable_reg} : 32'h0;

	// ----------------------------------------
	// Edge detection on pins
	// ----------------------------------------
	// Port D pins share the select bits of Port A pins 3 and 2
	wire [12:0] cur = {pins.port_a, pins.port_d, pins.port_c};
	// No edges in the first cycle after reset: prev_reg holds zeros, not the pins
	wire [12:0] rise = cur & ~prev_reg & {13{primed_reg}};
	wire [12:0] fall = ~cur & prev_reg & {13{primed_reg}};
	wire [9:0]  sel = {edge_reg, edge_reg[3:2]};
	wire [9:0]  ab_hit;

	// Selectable edge per pin, rising when select is one
	genvar g;
	generate
		for (g = 0; g < 10; g++) begin : g_edge
			assign ab_hit[g] = sel[g] ? rise[g + 3] : fall[g + 3];
		end
	endgenerate

	wire [7:0] pin_set = {
		ab_hit[9],
		ab_hit[8] | pins.compare,
		ab_hit[7:6],
		ab_hit[5] | ab_hit[1],
		ab_hit[4] | ab_hit[0],
		ab_hit[3:2]
	};
	wire [2:0] pc_set = rise[2:0] | fall[2:0];

	// ----------------------------------------
	// Pending state and acknowledge clears
	// ----------------------------------------
	wire [NSRC-1:0] ack_clr = vec_ack & vvalid_reg ? (NSRC'(1) << vidx_reg) : '0;
	wire            wr_bk1  = wr & hit_bk1;

	// Hardware set wins over a software write or an acknowledge; bank one
	// is stored pin 7 high, so its acknowledge slots are mirrored
	assign bank1_next = ((wr_bk1 ? pwdata[7:0] : bank1_reg) & ~rev8(ack_clr[17:10]))
		| pin_set;
	// Slots in rank order from bit 1 up; port C pin 3 leads its group
	assign other_next = (other_reg & ~{ack_clr[20:18], ack_clr[9:3]})
		| {pc_set[0], pc_set[1], pc_set[2], events.adc, events.tx, events.rx,
		   events.timer0, events.timer1, events.illegal, 1'b0};
	// Trap slots in rank order: watchdog, primary oscillator, watchdog oscillator
	wire [2:0] trap_set = {events.wosc_fail, events.posc_fail, events.wdt};
	logic [2:0] trap_reg;
	logic       rst_pend_reg;
	wire  [2:0] trap_next = (trap_reg & ~ack_clr[3:1]) | trap_set;
	wire        rst_next  = rst_pend_reg & ~ack_clr[0];

	// Full source vector in priority order
	wire [NSRC-1:0] src = {other_next[9:7], rev8(bank1_next),
		other_next[6:1], trap_next, rst_next};
	// Traps ignore the global enable, interrupts need it
	wire [NSRC-1:0] fwd = src & {{(NSRC - `VIPU_FIRST_MASK){gie_reg}},
		{`VIPU_FIRST_MASK{1'b1}}};
	wire [4:0] win = first_of(fwd);

	// Sticky trap status, set wins over clear
	assign status_next = (status_reg & ~((wr & hit_clr) ? pwdata[3:0] : 4'h0))
		| {events.wdt, events.posc_fail, events.wosc_fail, events.illegal};

	assign vec_valid = vvalid_reg;
	assign vec_addr  = vaddr_reg;
	assign irq       = |(status_reg & enable_reg);

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	// Reset request starts pending so the core first fetches its vector
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rst_pend_reg <= 1'b1;
			trap_reg     <= 3'h0;
			other_reg    <= 10'h000;
			bank1_reg    <= `VIPU_BANK1_RST;
			status_reg   <= 4'h0;
			prev_reg     <= 13'h0000;
			primed_reg   <= 1'b0;
		end else begin
			rst_pend_reg <= rst_next;
			trap_reg     <= trap_next;
			other_reg    <= other_next;
			bank1_reg    <= bank1_next;
			status_reg   <= status_next;
			prev_reg     <= cur;
			primed_reg   <= 1'b1;
		end
	end

	// Software control registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gie_reg    <= 1'b0;
			edge_reg   <= `VIPU_EDGE_RST;
			enable_reg <= 4'h0;
		end else begin
			if (wr & hit_ctl) begin
				gie_reg <= pwdata[`VIPU_CTRL_GIE];
			end
			if (wr & hit_edg) begin
				edge_reg <= pwdata[7:0];
			end
			if (wr & hit_ena) begin
				enable_reg <= pwdata[3:0];
			end
		end
	end

	// Read data captured in setup, presented in the access phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rdata_reg <= 32'h0;
		end else if (setup) begin
			rdata_reg <= (pwrite | ~mapped) ? 32'h0 : rmux;
		end
	end

	// Vector follows the pending state of the same edge, so an ack never
	// sees a stale winner
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			vvalid_reg <= 1'b0;
			vidx_reg   <= 5'h00;
			vaddr_reg  <= 16'h0000;
		end else begin
			vvalid_reg <= |fwd;
			vidx_reg   <= win;
			vaddr_reg  <= vec_of(win);
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	sequence s_reset_pend;
		rst_pend_reg;
	endsequence
	sequence s_rise7;
		primed_reg && edge_reg[7] && pins.port_a[7] && !prev_reg[12];
	endsequence

	reset_first_a: assert property (@(posedge pclk) disable iff (!presetn)
		s_reset_pend and vvalid_reg |-> vaddr_reg == 16'h0002)
		else $error("reset vector not presented first");
	wdt_rank_a: assert property (@(posedge pclk) disable iff (!presetn)
		vvalid_reg && !rst_pend_reg && trap_reg[0] |-> vaddr_reg == 16'h0004)
		else $error("watchdog vector wrong");
	posc_rank_a: assert property (@(posedge pclk) disable iff (!presetn)
		vvalid_reg && vidx_reg == 5'h02 |-> vaddr_reg == 16'h003A
		&& !rst_pend_reg && !trap_reg[0])
		else $error("oscillator trap vector or rank wrong");
	wosc_rank_a: assert property (@(posedge pclk) disable iff (!presetn)
		vvalid_reg && vidx_reg == 5'h03 |-> vaddr_reg == 16'h003C
		&& !trap_reg[1])
		else $error("watchdog oscillator trap wrong");
	ill_trap_a: assert property (@(posedge pclk) disable iff (!presetn)
		events.illegal && !gie_reg ##1 !rst_pend_reg && trap_reg == 3'h0
		|-> vvalid_reg && vaddr_reg == 16'h0006)
		else $error("illegal trap masked or misvectored");
	pin7_edge_a: assert property (@(posedge pclk) disable iff (!presetn)
		s_rise7 |=> bank1_reg[7])
		else $error("pin 7 rising edge lost");
	pin6_cmp_a: assert property (@(posedge pclk) disable iff (!presetn)
		pins.compare |=> bank1_reg[6])
		else $error("comparator request lost");
	pc_both_a: assert property (@(posedge pclk) disable iff (!presetn)
		primed_reg && $changed(pins.port_c[3]) |-> ##1 other_reg[7])
		else $error("port C edge lost");
	set_wins_a: assert property (@(posedge pclk) disable iff (!presetn)
		wr_bk1 && pwdata[0] == 1'b0 && ab_hit[2] |=> bank1_reg[0])
		else $error("clear beat a new request");
	gie_off_a: assert property (@(posedge pclk) disable iff (!presetn)
		!gie_reg [*2] |-> !vvalid_reg || vidx_reg < 5'h05)
		else $error("interrupt forwarded while disabled");
	gie_on_a: assert property (@(posedge pclk) disable iff (!presetn)
		gie_reg && bank1_reg != 8'h00 |-> vvalid_reg)
		else $error("pending bit not forwarded");
	bank_rw_a: assert property (@(posedge pclk) disable iff (!presetn)
		setup && !pwrite && hit_bk1 |=> prdata == {24'h0, $past(bank1_reg)})
		else $error("bank one readback wrong");
	prio_t1_a: assert property (@(posedge pclk) disable iff (!presetn)
		vvalid_reg && vidx_reg == 5'h0A |-> other_reg[6:2] == 5'h00)
		else $error("port source beat a peripheral");

	// Acknowledge, sharing and rank of the port sources, and no port C edge after reset
	ack_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
		vec_ack && vvalid_reg && vidx_reg == 5'h0A && !pin_set[7] && !wr_bk1
		|=> !bank1_reg[7])
		else $error("acknowledged pin 7 request still pending");
	pd3_share_a: assert property (@(posedge pclk) disable iff (!presetn)
		ab_hit[1] |=> bank1_reg[3])
		else $error("port D pin 3 edge lost");
	pd2_share_a: assert property (@(posedge pclk) disable iff (!presetn)
		ab_hit[0] |=> bank1_reg[2])
		else $error("port D pin 2 edge lost");
	pin5_rank_a: assert property (@(posedge pclk) disable iff (!presetn)
		vvalid_reg && vidx_reg == 5'h0C |-> vaddr_reg == 16'h001C && bank1_reg[7:6] == 2'b00)
		else $error("pin 5 vector or rank wrong");
	reset_quiet_a: assert property (@(posedge pclk) disable iff (!presetn)
		!primed_reg |=> other_reg[9:7] == 3'h0)
		else $error("false port C edge after reset");

endmodule

`default_nettype wire

// [src/vipu_defs.svh]
/*
 * Offsets, field positions, reset values and vector addresses of the
 * vectored interrupt priority unit.
 * Assumes a 32-bit APB slave with one register per aligned word.
 */
`ifndef VIPU_DEFS_SVH
`define VIPU_DEFS_SVH

// ----------------------------------------
// Register indices (byte address = 4 x index)
// ----------------------------------------
`define VIPU_IDX_CTRL      12'hFC0
`define VIPU_IDX_EDGE      12'hFC1
`define VIPU_IDX_BANK1     12'hFC3
`define VIPU_IDX_STATUS    12'hFC4
`define VIPU_IDX_CLEAR     12'hFC5
`define VIPU_IDX_ENABLE    12'hFC6

// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define VIPU_CTRL_GIE      0
`define VIPU_BANK1_RST     8'h00
`define VIPU_EDGE_RST      8'h00
`define VIPU_NSRC          21
`define VIPU_FIRST_MASK    5
`define VIPU_NSTAT         4

// ----------------------------------------
// Vector addresses by source index
// ----------------------------------------
`define VIPU_VEC_RESET     16'h0002
`define VIPU_VEC_WDT       16'h0004
`define VIPU_VEC_POSC      16'h003A
`define VIPU_VEC_WOSC      16'h003C
`define VIPU_VEC_ILL       16'h0006
`define VIPU_VEC_T1        16'h000A
`define VIPU_VEC_T0        16'h000C
`define VIPU_VEC_RX        16'h000E
`define VIPU_VEC_TX        16'h0010
`define VIPU_VEC_ADC       16'h0016
`define VIPU_VEC_PA7       16'h0018
`define VIPU_VEC_PA6       16'h001A
`define VIPU_VEC_PA5       16'h001C
`define VIPU_VEC_PA4       16'h001E
`define VIPU_VEC_PA3       16'h0020
`define VIPU_VEC_PA2       16'h0022
`define VIPU_VEC_PA1       16'h0024
`define VIPU_VEC_PA0       16'h0026
`define VIPU_VEC_PC3       16'h0030
`define VIPU_VEC_PC2       16'h0032
`define VIPU_VEC_PC1       16'h0034

`endif

// [src/vipu_pkg.sv]
/*
 * Types of the vectored interrupt priority unit.
 * Assumes vipu_defs.svh for the numbers.
 */
`default_nettype none

package vipu_pkg;

	// Pin inputs sampled for edge requests
	typedef struct packed {
		logic [7:0] port_a;
		logic [3:2] port_d;
		logic [3:1] port_c;
		logic       compare;
	} vipu_pins_t;

	// Trap and peripheral request pulses
	typedef struct packed {
		logic wdt;
		logic posc_fail;
		logic wosc_fail;
		logic illegal;
		logic timer1;
		logic timer0;
		logic rx;
		logic tx;
		logic adc;
	} vipu_events_t;

endpackage

`default_nettype wire

// [test/vipu_core_model.sv]
/*
 * Core-side model of the vector port: takes each presented vector and
 * logs it in order. Assumes vipu_top's vector port on pclk.
 */
`timescale 1ns/1ns
`default_nettype none

module vipu_core_model (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        ack_en,
	input  wire logic        vec_valid,
	input  wire logic [15:0] vec_addr,
	output logic             vec_ack
);
	logic [15:0] seen[$];

	// ----------------------------------------
	// Vector intake
	// ----------------------------------------
	// Ack every other cycle so each winner stands before it is taken
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			vec_ack <= 1'b0;
		end else begin
			if (vec_ack && vec_valid) begin
				seen.push_back(vec_addr);
			end
			vec_ack <= ack_en && vec_valid && !vec_ack;
		end
	end
endmodule

`default_nettype wire

// [test/vipu_top_tb_top.sv]
/*
 * Self-checking bench for vipu_top: APB tasks, pin and event stimulus,
 * vector order judged from the core model log.
 * Assumes the register indices of vipu_defs.svh, byte address 4 x index.
 */
`include "vipu_defs.svh"
`timescale 1ns/1ns
`default_nettype none

module vipu_top_tb_top;
	logic                   pclk = 1'b0;
	logic                   presetn = 1'b0;
	logic                   psel = 1'b0;
	logic                   penable = 1'b0;
	logic                   pwrite = 1'b0;
	logic [15:0]            paddr = 16'h0000;
	logic [31:0]            pwdata = 32'h0000_0000;
	logic [31:0]            prdata;
	logic                   pready;
	logic                   pslverr;
	logic                   vec_valid;
	logic                   vec_ack;
	logic                   irq;
	logic                   ack_en = 1'b1;
	logic [15:0]            vec_addr;
	vipu_pkg::vipu_pins_t   pins = {8'h0F, 2'h3, 3'h0, 1'h0};
	vipu_pkg::vipu_events_t events = '0;
	logic [31:0]            rd;
	logic                   er;
	logic [15:0]            exp_q[$];
	int                     err_count = 0;
	int                     tests_run = 0;

	// 125 MHz
	always #4 pclk = ~pclk;

	vipu_top i_vipu_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .pins(pins), .events(events), .vec_valid(vec_valid),
		.vec_addr(vec_addr), .vec_ack(vec_ack), .irq(irq));

	vipu_core_model i_vipu_core_model (.pclk(pclk), .presetn(presetn), .ack_en(ack_en),
		.vec_valid(vec_valid), .vec_addr(vec_addr), .vec_ack(vec_ack));

	// ----------------------------------------
	// Reporting
	// ----------------------------------------
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string m);
		tests_run++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR at %0t: %s got %h want %h", $time, m, got, exp);
		end
	endtask

	task automatic hang(input int n, input string m);
		if (n >= 200) begin
			check(32'h1, 32'h0, m);
			tally_and_finish();
		end
	endtask

	// ----------------------------------------
	// APB master
	// ----------------------------------------
	// Request held until pready is sampled high, then released
	task automatic apb(input logic wr, input logic [11:0] idx, input logic [31:0] wd);
		int n;
		n = 0;
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= {2'b00, idx, 2'b00};
		pwdata  <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 200);
		hang(n, "apb stall");
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [11:0] idx, input logic [31:0] wd);
		apb(1'b1, idx, wd);
	endtask

	task automatic rdchk(input logic [11:0] idx, input logic [31:0] exp, input string m);
		apb(1'b0, idx, 32'h0000_0000);
		check(rd, exp, m);
	endtask

	// ----------------------------------------
	// Stimulus and vector log
	// ----------------------------------------
	task automatic pulse(input vipu_pkg::vipu_events_t e, input logic cmp);
		@(posedge pclk);
		events       <= e;
		pins.compare <= cmp;
		@(posedge pclk);
		events       <= '0;
		pins.compare <= 1'b0;
	endtask

	// Let the core take everything, then compare its log
	task automatic drain(input string m);
		int n;
		n = 0;
		ack_en <= 1'b1;
		repeat (2) @(posedge pclk);
		#1;
		while ((vec_valid !== 1'b0 || vec_ack !== 1'b0) && n < 200) begin
			@(posedge pclk);
			#1;
			n++;
		end
		hang(n, "vector drain");
		check(32'(i_vipu_core_model.seen.size()), 32'(exp_q.size()), m);
		foreach (exp_q[i]) begin
			if (i < i_vipu_core_model.seen.size()) begin
				check({16'h0000, i_vipu_core_model.seen[i]}, {16'h0000, exp_q[i]}, m);
			end
		end
		i_vipu_core_model.seen.delete();
		$display("test %s done", m);
	endtask

	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		exp_q = '{16'h0002};
		drain("reset vector");
		rdchk(`VIPU_IDX_BANK1, 32'h0000_0000, "bank reset");
		// Traps are forwarded with global enable off
		ack_en <= 1'b0;
		wr(`VIPU_IDX_ENABLE, 32'h0000_000F);
		pulse(9'h1E0, 1'b0);
		repeat (2) @(posedge pclk);
		#1;
		check({31'h0, irq}, 32'h1, "irq set");
		rdchk(`VIPU_IDX_STATUS, 32'h0000_000F, "status set");
		exp_q = '{16'h0004, 16'h003A, 16'h003C, 16'h0006};
		drain("traps");
		wr(`VIPU_IDX_CLEAR, 32'h0000_0008);
		wr(`VIPU_IDX_STATUS, 32'h0000_0000);
		rdchk(`VIPU_IDX_STATUS, 32'h0000_0007, "status clear");
		wr(`VIPU_IDX_ENABLE, 32'h0000_0008);
		@(posedge pclk);
		#1;
		check({31'h0, irq}, 32'h0, "irq masked");
		apb(1'b0, 12'hFC2, 32'h0000_0000);
		check({31'h0, er}, 32'h1, "unmapped err");
		check(rd, 32'h0000_0000, "unmapped data");
		// Peripherals wait for global enable
		wr(`VIPU_IDX_CTRL, 32'h0000_0001);
		ack_en <= 1'b0;
		pulse(9'h01F, 1'b0);
		exp_q = '{16'h000A, 16'h000C, 16'h000E, 16'h0010, 16'h0016};
		drain("peripherals");
		// Polled pins: rising on 7..4, falling on 3..0
		wr(`VIPU_IDX_CTRL, 32'h0000_0000);
		wr(`VIPU_IDX_EDGE, 32'h0000_00F0);
		pins.port_a <= 8'hF0;
		repeat (3) @(posedge pclk);
		#1;
		check({31'h0, vec_valid}, 32'h0, "polled only");
		rdchk(`VIPU_IDX_BANK1, 32'h0000_00FF, "edge flags");
		wr(`VIPU_IDX_BANK1, 32'h0000_00A5);
		rdchk(`VIPU_IDX_BANK1, 32'h0000_00A5, "bank rw");
		wr(`VIPU_IDX_BANK1, 32'h0000_0000);
		pins.port_a <= 8'h0F;
		repeat (3) @(posedge pclk);
		rdchk(`VIPU_IDX_BANK1, 32'h0000_0000, "wrong edge");
		$display("test polled done");
		// Vectored pins, all at once
		wr(`VIPU_IDX_CTRL, 32'h0000_0001);
		ack_en <= 1'b0;
		pins.port_a <= 8'hF0;
		pins.port_c <= 3'h7;
		repeat (3) @(posedge pclk);
		exp_q = '{16'h0018, 16'h001A, 16'h001C, 16'h001E, 16'h0020, 16'h0022, 16'h0024,
			16'h0026, 16'h0030, 16'h0032, 16'h0034};
		drain("pin order");
		rdchk(`VIPU_IDX_BANK1, 32'h0000_0000, "acked");
		// Shared sources: comparator, port D, port C falling
		ack_en <= 1'b0;
		pins.port_d <= 2'h0;
		pins.port_c <= 3'h0;
		pulse(9'h000, 1'b1);
		repeat (2) @(posedge pclk);
		rdchk(`VIPU_IDX_BANK1, 32'h0000_004C, "shared flags");
		exp_q = '{16'h001A, 16'h0020, 16'h0022, 16'h0030, 16'h0032, 16'h0034};
		drain("shared");
		tally_and_finish();
	end
endmodule

`default_nettype wire
